// File: hdl/cjlx_pkg.sv
// Constants, encodings and state type for the conditional jump, far call and
// copy execution block.
// Assumes nothing beyond a SystemVerilog compiler; used by cjlx_cond and cjlx_exec.
package cjlx_pkg;

  // Opcodes of the short conditional jumps and the far relative call.
  localparam logic [7:0] OP_JUMP_IF_NONZERO = 8'hd7;
  localparam logic [7:0] OP_JUMP_IF_NOT_ABOVE = 8'hd1;
  localparam logic [7:0] OP_JUMP_IF_STICKY_CLEAR = 8'hd0;
  localparam logic [7:0] OP_JUMP_IF_NO_OVERFLOW = 8'hd5;
  localparam logic [7:0] OP_JUMP_IF_TRAP_CLEAR = 8'hd4;
  localparam logic [7:0] OP_JUMP_IF_STICKY_SET = 8'hd8;
  localparam logic [7:0] OP_JUMP_IF_OVERFLOW = 8'hdd;
  localparam logic [7:0] OP_JUMP_IF_TRAP_SET = 8'hdc;
  localparam logic [7:0] OP_FAR_RELATIVE_CALL = 8'hef;

  // Upper six opcode bits of the copy instructions; the low two give the mode.
  localparam logic [5:0] OP_WORD_COPY = 6'h28;
  localparam logic [5:0] OP_BYTE_COPY = 6'h2c;
  localparam logic [5:0] OP_BYTE_TO_WORD_SIGNED_COPY = 6'h2f;

  // Source addressing modes.
  localparam logic [1:0] AM_DIRECT = 2'h0;
  localparam logic [1:0] AM_IMMEDIATE = 2'h1;
  localparam logic [1:0] AM_INDIRECT = 2'h2;
  localparam logic [1:0] AM_INDEXED = 2'h3;

  // Flag positions inside the six-bit flag vector.
  localparam int unsigned FLG_ZERO = 0;
  localparam int unsigned FLG_NEG = 1;
  localparam int unsigned FLG_CARRY = 2;
  localparam int unsigned FLG_OVF = 3;
  localparam int unsigned FLG_TRAP = 4;
  localparam int unsigned FLG_STICKY = 5;
  localparam int unsigned FLAG_W = 6;

  // State-time counts.
  localparam logic [4:0] ST_JUMP_NOT_TAKEN = 5'h04;
  localparam logic [4:0] ST_JUMP_TAKEN = 5'h08;
  localparam logic [4:0] ST_CALL_ONCHIP = 5'h0d;
  localparam logic [4:0] ST_CALL_OFFCHIP = 5'h10;
  localparam logic [4:0] ST_COPY_BASE = 5'h04;
  localparam logic [4:0] ST_EXTRA_DIRECT = 5'h00;
  localparam logic [4:0] ST_EXTRA_IMMEDIATE = 5'h01;
  localparam logic [4:0] ST_EXTRA_INDIRECT = 5'h02;
  localparam logic [4:0] ST_EXTRA_INDEXED = 5'h03;

  // Data constants.
  localparam logic [7:0] SIGN_LIMIT = 8'h80;
  localparam logic [7:0] HIGH_ONES = 8'hff;
  localparam logic [7:0] HIGH_ZERO = 8'h00;
  localparam logic [7:0] REG_PAGE = 8'h00;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] NEXT_BYTE = 16'h0001;

  // Instruction kinds and sequencer states.
  typedef enum logic [1:0] {K_JUMP, K_CALL, K_COPY} cjlx_kind_t;
  typedef enum logic [1:0] {C_WORD, C_BYTE, C_SEXT} cjlx_copy_t;
  typedef enum {S_IDLE, S_DISP, S_CALL_LO, S_CALL_HI, S_OPND_A, S_OPND_B, S_DEST, S_WAIT, S_FIN} cjlx_state_t;

endpackage

// File: hdl/cjlx_cond_if.sv
// Carrier between the sequencer and the jump condition evaluator.
// Assumes both ends sit on the same clock; all signals are combinational.
`timescale 1ns/1ps
`default_nettype none
interface cjlx_cond_if;
  logic [7:0] opcode; // Opcode under evaluation.
  logic [5:0] flags; // Current flag vector.
  logic [7:0] disp; // Displacement byte.
  logic [15:0] next_pc; // Address after the displacement byte.
  logic is_jump; // Opcode is one of the eight short jumps.
  logic taken; // Condition holds.
  logic clr_trap; // Jump clears the overflow trap flag.
  logic [15:0] target; // Address to continue at.

  modport seq (output opcode, flags, disp, next_pc, input is_jump, taken, clr_trap, target);
  modport eval (input opcode, flags, disp, next_pc, output is_jump, taken, clr_trap, target);
endinterface
`default_nettype wire

// File: hdl/cjlx_cond.sv
// Condition evaluator for the short conditional jumps: decides the jump and
// forms the continuation address.
// Assumes the sequencer presents a stable opcode, flags and displacement.
`timescale 1ns/1ps
`default_nettype none
module cjlx_cond (
  cjlx_cond_if.eval c // Evaluation side of the carrier.
);

  logic [15:0] disp_ext;

  // The displacement reaches -128 to +127 from the byte after the jump.
  assign disp_ext = {{8{c.disp[7]}}, c.disp};
  assign c.target = c.taken ? c.next_pc + disp_ext : c.next_pc;

  // Condition table; the two trap tests also consume the trap flag.
  always_comb
  begin
    c.is_jump = 1'b1;
    c.taken = 1'b0;
    c.clr_trap = 1'b0;
    unique case (c.opcode)
      cjlx_pkg::OP_JUMP_IF_NONZERO: c.taken = ~c.flags[cjlx_pkg::FLG_ZERO];
      cjlx_pkg::OP_JUMP_IF_NOT_ABOVE:
      begin
        c.taken = ~c.flags[cjlx_pkg::FLG_CARRY] | c.flags[cjlx_pkg::FLG_ZERO];
      end
      cjlx_pkg::OP_JUMP_IF_STICKY_CLEAR: c.taken = ~c.flags[cjlx_pkg::FLG_STICKY];
      cjlx_pkg::OP_JUMP_IF_NO_OVERFLOW: c.taken = ~c.flags[cjlx_pkg::FLG_OVF];
      cjlx_pkg::OP_JUMP_IF_TRAP_CLEAR:
      begin
        c.taken = ~c.flags[cjlx_pkg::FLG_TRAP];
        c.clr_trap = 1'b1;
      end
      cjlx_pkg::OP_JUMP_IF_STICKY_SET: c.taken = c.flags[cjlx_pkg::FLG_STICKY];
      cjlx_pkg::OP_JUMP_IF_OVERFLOW: c.taken = c.flags[cjlx_pkg::FLG_OVF];
      cjlx_pkg::OP_JUMP_IF_TRAP_SET:
      begin
        c.taken = c.flags[cjlx_pkg::FLG_TRAP];
        c.clr_trap = 1'b1;
      end
      default: c.is_jump = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/cjlx_exec.sv
// Execution block for short conditional jumps, the far relative call and the
// word, byte and sign-extending copies.
// Assumes a byte fetch stream whose fetch_pc_i is the address of the byte on
// offer, and a register/data port that answers a read one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cjlx_exec #(
  parameter int unsigned STATE_CYC = 2 // Clock cycles per state time.
) (
  input wire logic clk_i, // Core clock, 100 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic fetch_valid_i, // A fetched byte is on offer.
  input wire logic [7:0] fetch_byte_i, // The byte on offer.
  input wire logic [15:0] fetch_pc_i, // Address of the byte on offer.
  output logic fetch_take_o, // Byte taken this cycle.
  output logic foreign_op_o, // Byte on offer in idle is not handled here.
  input wire logic [5:0] flags_i, // Flags: Z N C V trap sticky, bit 0 up.
  input wire logic [15:0] sp_i, // Current stack pointer.
  input wire logic stack_offchip_i, // High when the stack lies off chip.
  output logic rd_en_o, // Read strobe to register/data space.
  output logic [15:0] rd_addr_o, // Read address.
  input wire logic [15:0] rd_data_i, // Read word, the cycle after rd_en_o.
  output logic wr_en_o, // Write strobe, one cycle.
  output logic wr_byte_o, // Write only the low byte.
  output logic [15:0] wr_addr_o, // Write address.
  output logic [15:0] wr_data_o, // Write data.
  output logic sp_wr_o, // Load stack pointer, one cycle.
  output logic [15:0] sp_o, // New stack pointer.
  output logic flags_wr_o, // Load flags, one cycle.
  output logic [5:0] flags_o, // New flags.
  output logic pc_load_o, // Load program counter, one cycle.
  output logic [15:0] pc_o, // New program counter.
  output logic busy_o, // An instruction is executing.
  output logic done_o // Instruction finished, one cycle.
);

  localparam logic [7:0] STATE_CYC_W = 8'(STATE_CYC);
  localparam logic [7:0] TWO_CYC = 8'h02;

  // Elaboration-time guard: STATE_CYC is held to one to eight cycles a state; the 8-bit cycle counter would serve up to fifteen.
  if (STATE_CYC < 1 || STATE_CYC > 8)
  begin
    $error("STATE_CYC must lie in 1..8");
  end

  cjlx_pkg::cjlx_state_t state_q;
  cjlx_pkg::cjlx_kind_t kind_q;
  cjlx_pkg::cjlx_copy_t copy_q;
  logic [7:0] op_q;
  logic [1:0] mode_q;
  logic [7:0] disp_lo_q;
  logic [4:0] need_st_q;
  logic [7:0] need_cyc;
  logic [7:0] cyc_q;
  logic trap_q;
  logic [15:0] src_q;
  logic rd_en_q;
  logic [15:0] rd_addr_q;
  logic rd_pend_q;
  logic ind_q;
  logic [15:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic wr_byte_q;
  logic [15:0] sp_q;
  logic [5:0] flags_q;
  logic [15:0] pc_q;
  logic take;
  logic is_copy;
  logic reads_idle;
  logic finish;
  logic [15:0] base_val;
  logic [15:0] after_byte;
  logic [4:0] extra_st;

  cjlx_cond_if cond ();

  cjlx_cond u_cond (
    .c(cond)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and handshake.

  // The evaluator looks at the byte on offer in idle, later at the opcode held.
  assign cond.opcode = (state_q == cjlx_pkg::S_IDLE) ? fetch_byte_i : op_q;
  assign cond.flags = flags_i;
  assign cond.disp = fetch_byte_i;
  assign after_byte = fetch_pc_i + cjlx_pkg::NEXT_BYTE;
  assign cond.next_pc = after_byte;

  assign is_copy = (fetch_byte_i[7:2] == cjlx_pkg::OP_WORD_COPY)
                 || (fetch_byte_i[7:2] == cjlx_pkg::OP_BYTE_COPY)
                 || (fetch_byte_i[7:2] == cjlx_pkg::OP_BYTE_TO_WORD_SIGNED_COPY);
  assign reads_idle = !rd_en_q && !rd_pend_q;
  assign base_val = rd_pend_q ? rd_data_i : src_q;
  assign need_cyc = 8'(need_st_q) * STATE_CYC_W;
  assign finish = (state_q == cjlx_pkg::S_WAIT) && reads_idle && (cyc_q >= need_cyc - TWO_CYC);

  // Indexed mode holds the offset byte until the base register has returned.
  always_comb
  begin
    unique case (state_q)
      cjlx_pkg::S_IDLE: fetch_take_o = cond.is_jump || is_copy || (fetch_byte_i == cjlx_pkg::OP_FAR_RELATIVE_CALL);
      cjlx_pkg::S_DISP, cjlx_pkg::S_CALL_LO, cjlx_pkg::S_CALL_HI, cjlx_pkg::S_OPND_A,
      cjlx_pkg::S_DEST: fetch_take_o = 1'b1;
      cjlx_pkg::S_OPND_B: fetch_take_o = (mode_q != cjlx_pkg::AM_INDEXED) || reads_idle;
      cjlx_pkg::S_WAIT, cjlx_pkg::S_FIN: fetch_take_o = 1'b0;
    endcase
  end
  assign take = fetch_valid_i && fetch_take_o;
  assign foreign_op_o = (state_q == cjlx_pkg::S_IDLE) && fetch_valid_i && !fetch_take_o;

  // Extra state times of the source mode.
  always_comb
  begin
    unique case (mode_q)
      cjlx_pkg::AM_DIRECT: extra_st = cjlx_pkg::ST_EXTRA_DIRECT;
      cjlx_pkg::AM_IMMEDIATE: extra_st = cjlx_pkg::ST_EXTRA_IMMEDIATE;
      cjlx_pkg::AM_INDIRECT: extra_st = cjlx_pkg::ST_EXTRA_INDIRECT;
      cjlx_pkg::AM_INDEXED: extra_st = cjlx_pkg::ST_EXTRA_INDEXED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Operand bytes are taken in stream order; the wait state pads to the count.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= cjlx_pkg::S_IDLE;
    end
    else
    begin
      unique case (state_q)
        cjlx_pkg::S_IDLE:
        begin
          if (take && cond.is_jump)
          begin
            state_q <= cjlx_pkg::S_DISP;
          end
          else if (take && is_copy)
          begin
            state_q <= cjlx_pkg::S_OPND_A;
          end
          else if (take)
          begin
            state_q <= cjlx_pkg::S_CALL_LO;
          end
        end
        cjlx_pkg::S_DISP: if (take) state_q <= cjlx_pkg::S_WAIT;
        cjlx_pkg::S_CALL_LO: if (take) state_q <= cjlx_pkg::S_CALL_HI;
        cjlx_pkg::S_CALL_HI: if (take) state_q <= cjlx_pkg::S_WAIT;
        cjlx_pkg::S_OPND_A:
        begin
          if (take)
          begin
            // Word immediates and indexed sources need a second operand byte.
            if ((mode_q == cjlx_pkg::AM_INDEXED) || (mode_q == cjlx_pkg::AM_IMMEDIATE && copy_q == cjlx_pkg::C_WORD))
            begin
              state_q <= cjlx_pkg::S_OPND_B;
            end
            else
            begin
              state_q <= cjlx_pkg::S_DEST;
            end
          end
        end
        cjlx_pkg::S_OPND_B: if (take) state_q <= cjlx_pkg::S_DEST;
        cjlx_pkg::S_DEST: if (take) state_q <= cjlx_pkg::S_WAIT;
        cjlx_pkg::S_WAIT: if (finish) state_q <= cjlx_pkg::S_FIN;
        cjlx_pkg::S_FIN: state_q <= cjlx_pkg::S_IDLE;
      endcase
    end
  end

  // Opcode, kind and mode are latched with the opcode byte.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      op_q <= 8'h00;
      mode_q <= cjlx_pkg::AM_DIRECT;
      kind_q <= cjlx_pkg::K_JUMP;
      copy_q <= cjlx_pkg::C_WORD;
    end
    else if (take && state_q == cjlx_pkg::S_IDLE)
    begin
      op_q <= fetch_byte_i;
      mode_q <= fetch_byte_i[1:0];
      kind_q <= cond.is_jump ? cjlx_pkg::K_JUMP : (is_copy ? cjlx_pkg::K_COPY : cjlx_pkg::K_CALL);
      if (fetch_byte_i[7:2] == cjlx_pkg::OP_BYTE_COPY)
      begin
        copy_q <= cjlx_pkg::C_BYTE;
      end
      else if (fetch_byte_i[7:2] == cjlx_pkg::OP_BYTE_TO_WORD_SIGNED_COPY)
      begin
        copy_q <= cjlx_pkg::C_SEXT;
      end
      else
      begin
        copy_q <= cjlx_pkg::C_WORD;
      end
    end
  end

  // Cycle count from the opcode byte, which is cycle 0.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cyc_q <= 8'h00;
    end
    else if (take && state_q == cjlx_pkg::S_IDLE)
    begin
      cyc_q <= 8'h01;
    end
    else if (state_q != cjlx_pkg::S_IDLE && cyc_q != 8'hff)
    begin
      cyc_q <= cyc_q + 8'h01;
    end
  end

  // State-time budget; fetch stalls may stretch it but never shorten it.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      need_st_q <= cjlx_pkg::ST_JUMP_NOT_TAKEN;
    end
    else if (take && state_q == cjlx_pkg::S_DISP)
    begin
      need_st_q <= cond.taken ? cjlx_pkg::ST_JUMP_TAKEN : cjlx_pkg::ST_JUMP_NOT_TAKEN;
    end
    else if (take && state_q == cjlx_pkg::S_CALL_HI)
    begin
      need_st_q <= stack_offchip_i ? cjlx_pkg::ST_CALL_OFFCHIP : cjlx_pkg::ST_CALL_ONCHIP;
    end
    else if (take && state_q == cjlx_pkg::S_DEST)
    begin
      need_st_q <= cjlx_pkg::ST_COPY_BASE + extra_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control flow results.

  // Jumps and the call set the new program counter and stack pointer.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_q <= 16'h0000;
      disp_lo_q <= 8'h00;
      sp_q <= 16'h0000;
      flags_q <= 6'h00;
      trap_q <= 1'b0;
    end
    else if (take && state_q == cjlx_pkg::S_DISP)
    begin
      pc_q <= cond.target;
      flags_q <= flags_i & ~(6'h01 << cjlx_pkg::FLG_TRAP);
      trap_q <= cond.clr_trap;
    end
    else if (take && state_q == cjlx_pkg::S_CALL_LO)
    begin
      disp_lo_q <= fetch_byte_i;
      trap_q <= 1'b0;
    end
    else if (take && state_q == cjlx_pkg::S_CALL_HI)
    begin
      pc_q <= after_byte + {fetch_byte_i, disp_lo_q};
      sp_q <= sp_i - cjlx_pkg::STACK_STEP;
    end
    else if (take && state_q == cjlx_pkg::S_IDLE)
    begin
      trap_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand reads.

  // One read in flight at a time; indirect mode chains a second read.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_en_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      rd_pend_q <= 1'b0;
      ind_q <= 1'b0;
      src_q <= 16'h0000;
    end
    else
    begin
      rd_en_q <= 1'b0;
      rd_pend_q <= rd_en_q;
      if (rd_pend_q)
      begin
        if (ind_q)
        begin
          rd_en_q <= 1'b1;
          rd_addr_q <= rd_data_i;
          ind_q <= 1'b0;
        end
        else
        begin
          src_q <= rd_data_i;
        end
      end
      if (take && state_q == cjlx_pkg::S_OPND_A)
      begin
        unique case (mode_q)
          cjlx_pkg::AM_IMMEDIATE: src_q <= {8'h00, fetch_byte_i};
          cjlx_pkg::AM_INDIRECT:
          begin
            rd_en_q <= 1'b1;
            rd_addr_q <= {cjlx_pkg::REG_PAGE, fetch_byte_i};
            ind_q <= 1'b1;
          end
          cjlx_pkg::AM_DIRECT, cjlx_pkg::AM_INDEXED:
          begin
            rd_en_q <= 1'b1;
            rd_addr_q <= {cjlx_pkg::REG_PAGE, fetch_byte_i};
          end
        endcase
      end
      if (take && state_q == cjlx_pkg::S_OPND_B)
      begin
        if (mode_q == cjlx_pkg::AM_IMMEDIATE)
        begin
          src_q[15:8] <= fetch_byte_i;
        end
        else
        begin
          // Short indexed form: base register plus signed offset byte.
          rd_en_q <= 1'b1;
          rd_addr_q <= base_val + {{8{fetch_byte_i[7]}}, fetch_byte_i};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination write.

  // The call pushes its return address; copies write the destination register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      wr_byte_q <= 1'b0;
    end
    else if (take && state_q == cjlx_pkg::S_CALL_HI)
    begin
      wr_addr_q <= sp_i - cjlx_pkg::STACK_STEP;
      wr_data_q <= after_byte;
      wr_byte_q <= 1'b0;
    end
    else if (take && state_q == cjlx_pkg::S_DEST)
    begin
      wr_addr_q <= {cjlx_pkg::REG_PAGE, fetch_byte_i};
    end
    else if (finish && kind_q == cjlx_pkg::K_COPY)
    begin
      unique case (copy_q)
        cjlx_pkg::C_WORD:
        begin
          wr_data_q <= src_q;
          wr_byte_q <= 1'b0;
        end
        cjlx_pkg::C_BYTE:
        begin
          wr_data_q <= {8'h00, src_q[7:0]};
          wr_byte_q <= 1'b1;
        end
        cjlx_pkg::C_SEXT:
        begin
          // High byte from the source sign, judged against the limit.
          wr_data_q <= {(src_q[7:0] < cjlx_pkg::SIGN_LIMIT) ? cjlx_pkg::HIGH_ZERO : cjlx_pkg::HIGH_ONES,
                        src_q[7:0]};
          wr_byte_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Strobes fire in the single finishing cycle; copies never touch the flags.
  assign wr_en_o = (state_q == cjlx_pkg::S_FIN) && (kind_q != cjlx_pkg::K_JUMP);
  assign sp_wr_o = (state_q == cjlx_pkg::S_FIN) && (kind_q == cjlx_pkg::K_CALL);
  assign pc_load_o = (state_q == cjlx_pkg::S_FIN) && (kind_q != cjlx_pkg::K_COPY);
  assign flags_wr_o = (state_q == cjlx_pkg::S_FIN) && (kind_q == cjlx_pkg::K_JUMP) && trap_q;
  assign done_o = (state_q == cjlx_pkg::S_FIN);
  assign busy_o = (state_q != cjlx_pkg::S_IDLE);
  assign rd_en_o = rd_en_q;
  assign rd_addr_o = rd_addr_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
  assign wr_byte_o = wr_byte_q;
  assign sp_o = sp_q;
  assign flags_o = flags_q;
  assign pc_o = pc_q;

endmodule
`default_nettype wire

// File: tb/cjlx_reg_model.sv
// Register space model on the far side of the execution block.
// Assumes one read in flight; a word is valid only in the cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module cjlx_reg_model (
  input wire logic clk_i, // Core clock.
  input wire logic rd_en_i, // Read strobe.
  input wire logic [15:0] rd_addr_i, // Read address.
  output var logic [15:0] rd_data_o // Read word.
);
  // Each register holds its own number below and its inverse above, so a
  // wrong address shows; outside the answer cycle the word keeps toggling.
  always_ff @(posedge clk_i)
  begin
    if (rd_en_i)
      rd_data_o <= {~rd_addr_i[7:0], rd_addr_i[7:0]};
    else
      rd_data_o <= ~rd_data_o;
  end
endmodule
`default_nettype wire

// File: tb/cjlx_chk.sv
// Port-level checks of the execution block.
// Assumes a single clock domain with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cjlx_chk #(
  parameter int unsigned STATE_CYC = 2 // Cycles per state time.
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, low.
  input wire logic fetch_valid_i, // Byte offered.
  input wire logic [7:0] fetch_byte_i, // Offered byte.
  input wire logic fetch_take_o, // Byte taken.
  input wire logic wr_en_o, // Write pulse.
  input wire logic wr_byte_o, // Low byte only.
  input wire logic [15:0] wr_addr_o, // Write address.
  input wire logic sp_wr_o, // Stack load.
  input wire logic [15:0] sp_o, // New stack pointer.
  input wire logic flags_wr_o, // Flag load.
  input wire logic [5:0] flags_o, // New flags.
  input wire logic pc_load_o, // Counter load.
  input wire logic busy_o, // Executing.
  input wire logic done_o // Finished.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Results of finishing instructions.
  AST_TRAP_CLR: assert property (flags_wr_o |-> !flags_o[4] && done_o && pc_load_o)
    else $error("trap flag not cleared at flag load");
  AST_CALL_PUSH: assert property (sp_wr_o |-> wr_en_o && sp_o == wr_addr_o && pc_load_o && !flags_wr_o)
    else $error("call push inconsistent");
  AST_COPY_QUIET: assert property (wr_en_o && !sp_wr_o |-> done_o && !flags_wr_o && !pc_load_o)
    else $error("copy touched flags or counter");
  AST_BYTE_WR: assert property (wr_en_o && wr_byte_o |-> !sp_wr_o)
    else $error("byte write during call");
  AST_PC_PULSE: assert property (pc_load_o |-> done_o ##1 !pc_load_o && !busy_o)
    else $error("counter load not a single finishing pulse");
  // A short instruction never finishes before four state times.
  AST_MIN_TIME: assert property ($rose(busy_o) && STATE_CYC >= 2 |-> !done_o [*6])
    else $error("instruction finished too early");

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance of opcodes while idle.
  AST_TAKE_JMP: assert property (!busy_o && fetch_valid_i && fetch_byte_i inside {8'hd7, 8'hd1, 8'hd0,
    8'hd5, 8'hd4, 8'hd8, 8'hdd, 8'hdc, 8'hef} |-> fetch_take_o)
    else $error("jump or call opcode not taken");
  AST_TAKE_CPY: assert property (!busy_o && fetch_valid_i && fetch_byte_i[7:2] inside {6'h28, 6'h2c,
    6'h2f} |-> fetch_take_o)
    else $error("copy opcode not taken");
endmodule

bind cjlx_exec cjlx_chk #(.STATE_CYC(STATE_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i),
  .fetch_take_o(fetch_take_o), .wr_en_o(wr_en_o), .wr_byte_o(wr_byte_o), .wr_addr_o(wr_addr_o),
  .sp_wr_o(sp_wr_o), .sp_o(sp_o), .flags_wr_o(flags_wr_o), .flags_o(flags_o), .pc_load_o(pc_load_o),
  .busy_o(busy_o), .done_o(done_o)
);
`default_nettype wire

// File: tb/cjlx_exec_tb.sv
// Self-checking bench: feeds the fetch stream, flags and stack inputs.
// Assumes the register model answers a read in the following cycle.
`timescale 1ns/1ps
`default_nettype none
module cjlx_exec_tb;
  localparam int SC = 2;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fetch_valid_i = 1'b0;
  logic [7:0] fetch_byte_i = 8'h00;
  logic [15:0] fetch_pc_i = 16'h0000;
  logic [5:0] flags_i = 6'h00;
  logic [15:0] sp_i = 16'h0000;
  logic stack_offchip_i = 1'b0;
  logic [15:0] rd_data_i;
  logic fetch_take_o, foreign_op_o, rd_en_o, wr_en_o, wr_byte_o, sp_wr_o;
  logic flags_wr_o, pc_load_o, busy_o, done_o;
  logic [15:0] rd_addr_o, wr_addr_o, wr_data_o, sp_o, pc_o;
  logic [5:0] flags_o;
  logic [7:0] pb[4];
  logic [15:0] pc0;
  logic [3:0] pul;
  int t;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] jop[8] = '{8'hd7, 8'hd1, 8'hd0, 8'hd5, 8'hd4, 8'hd8, 8'hdd, 8'hdc};
  logic [5:0] ftk[8] = '{6'h00, 6'h05, 6'h1f, 6'h37, 6'h2f, 6'h20, 6'h08, 6'h3f};
  logic [5:0] fnt[8] = '{6'h01, 6'h04, 6'h20, 6'h08, 6'h10, 6'h1f, 6'h37, 6'h2f};
  logic [7:0] cop[7] = '{8'ha0, 8'hb0, 8'hbc, 8'hbc, 8'ha1, 8'ha2, 8'ha3};
  logic [7:0] csb[7] = '{8'h34, 8'h56, 8'h7f, 8'h80, 8'hcd, 8'h12, 8'h20};
  logic [7:0] cs2[7] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hab, 8'h40, 8'h05};
  logic [15:0] cex[7] = '{16'hcb34, 16'h0056, 16'h007f, 16'hff80, 16'habcd, 16'hed12, 16'hda25};
  // State times per copy: four plus 0 direct, 1 immediate, 2 indirect, 3 indexed.
  int cst[7] = '{4, 4, 4, 4, 5, 6, 7};

  cjlx_exec #(.STATE_CYC(SC)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i),
    .fetch_pc_i(fetch_pc_i), .fetch_take_o(fetch_take_o), .foreign_op_o(foreign_op_o), .flags_i(flags_i),
    .sp_i(sp_i), .stack_offchip_i(stack_offchip_i), .rd_en_o(rd_en_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .wr_en_o(wr_en_o), .wr_byte_o(wr_byte_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .sp_wr_o(sp_wr_o), .sp_o(sp_o), .flags_wr_o(flags_wr_o), .flags_o(flags_o),
    .pc_load_o(pc_load_o), .pc_o(pc_o), .busy_o(busy_o), .done_o(done_o)
  );
  cjlx_reg_model u_reg (.clk_i(clk_i), .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i));

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Compare, closing and instruction tasks.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Streams n bytes back to back and times done from the opcode edge.
  // Take is sampled at the falling edge, where it has settled.
  // t ends as the edge that launches done, which stands in the last cycle, so t is cycles minus two.
  task automatic run(input int n);
    int i;
    int k;
    logic tk;
    i = 0;
    k = 0;
    t = -1;
    fetch_valid_i <= 1'b1;
    fetch_byte_i <= pb[0];
    fetch_pc_i <= pc0;
    while (k < 100)
    begin
      @(negedge clk_i);
      if (i == n && done_o === 1'b1)
        break;
      tk = i < n && fetch_take_o === 1'b1;
      @(posedge clk_i);
      k++;
      if (tk || t >= 0)
        t++;
      if (tk)
        i++;
      if (tk && i < n)
      begin
        fetch_byte_i <= pb[i];
        fetch_pc_i <= pc0 + 16'(i);
      end
      if (tk && i == n)
        fetch_valid_i <= 1'b0;
    end
    pul = {flags_wr_o, pc_load_o, wr_en_o, sp_wr_o};
    if (k == 100)
      chk("done", 16'h0001, 16'h0000);
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    int j;
    logic tk;
    logic [7:0] d;
    logic [5:0] f;
    logic [15:0] nx;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Every jump taken with the most negative reach, then untaken.
    for (int i = 0; i < 16; i++)
    begin
      j = i / 2;
      tk = (i % 2) == 0;
      d = tk ? 8'h80 : 8'h7f;
      f = tk ? ftk[j] : fnt[j];
      pc0 = 16'h0100 + 16'(i * 16);
      nx = pc0 + 16'h0002;
      flags_i <= f;
      pb = '{jop[j], d, 8'h00, 8'h00};
      run(2);
      chk("pc", tk ? nx + {{8{d[7]}}, d} : nx, pc_o);
      chk("cyc", tk ? 16'(8 * SC - 2) : 16'(4 * SC - 2), 16'(t));
      chk("pulse", {12'h0, j == 4 || j == 7, 3'b100}, {12'h0, pul});
      if (j == 4 || j == 7)
        chk("flags", {10'h0, f & 6'h2f}, {10'h0, flags_o});
    end
    $display("jumps done");
    // Far call with the stack on and off chip.
    for (int oc = 0; oc < 2; oc++)
    begin
      sp_i <= 16'h0200;
      stack_offchip_i <= oc[0];
      pc0 = 16'h1000;
      pb = '{8'hef, 8'h01, 8'h80, 8'h00};
      run(3);
      chk("ret", 16'h1003, wr_data_o);
      chk("push", 16'h01fe, wr_addr_o);
      chk("sp", 16'h01fe, sp_o);
      chk("pc", 16'h1003 + 16'h8001, pc_o);
      chk("pulse", 16'h0007, {12'h0, pul});
      chk("cyc", oc == 1 ? 16'(16 * SC - 2) : 16'(13 * SC - 2), 16'(t));
    end
    $display("calls done");
    // Word, byte, signed both sides of the sign limit, then immediate, indirect and indexed word.
    for (int k = 0; k < 7; k++)
    begin
      pc0 = 16'h2000;
      pb = '{cop[k], csb[k], cs2[k], 8'h40};
      run(cs2[k] == 8'h40 ? 3 : 4);
      chk("data", cex[k], k == 1 ? wr_data_o & 16'h00ff : wr_data_o);
      chk("dest", 16'h0040, wr_addr_o);
      chk("wbyte", {15'h0, k == 1}, {15'h0, wr_byte_o});
      chk("pulse", 16'h0002, {12'h0, pul});
      chk("cyc", 16'(cst[k] * SC - 2), 16'(t));
    end
    $display("copies done");
    // A foreign opcode is left on offer.
    fetch_valid_i <= 1'b1;
    fetch_byte_i <= 8'h00;
    @(negedge clk_i);
    chk("refuse", 16'h0002, {13'h0, busy_o, foreign_op_o, fetch_take_o});
    @(posedge clk_i);
    fetch_valid_i <= 1'b0;
    $display("refusal done");
    end_of_test();
  end
endmodule
`default_nettype wire
